// [pkg/csd_pkg.sv]
package csd_pkg;
	// =========================================================
	// register map
	localparam logic [7:0] CSD_REG_CTRL  = 8'h00;
	localparam logic [7:0] CSD_REG_MADDR = 8'h04;
	localparam logic [7:0] CSD_REG_MDATA = 8'h08;
	localparam logic [7:0] CSD_REG_STAT  = 8'h0C;
	localparam logic [7:0] CSD_REG_LAST  = 8'h10;
	localparam int CSD_CTRL_EN    = 0;
	localparam int CSD_CTRL_BUSY  = 1;
	localparam int CSD_CTRL_CU    = 8;
	localparam int CSD_CTRL_BDEV  = 16;
	localparam int CSD_STAT_ZERO  = 0;
	localparam int CSD_STAT_SRES  = 1;
	localparam int CSD_STAT_IDSC  = 2;
	localparam int CSD_STAT_CERR  = 3;
	localparam int CSD_STAT_CREJ  = 4;
	localparam int CSD_STAT_STATE = 8;
	localparam logic [31:0] CSD_CTRL_RST = 32'h0000_0000;
	// =========================================================
	// communication memory
	localparam int CSD_MEM_AW = 7;
	localparam int CSD_MEM_DEPTH = 128;
	localparam logic [6:0] CSD_STAT_BASE  = 7'h00;
	localparam logic [6:0] CSD_SENSE_BASE = 7'h20;
	localparam logic [6:0] CSD_ID_BASE    = 7'h6F;
	localparam logic [2:0] CSD_ID_LEN     = 3'h4;
	// =========================================================
	// command codes
	localparam logic [7:0] CSD_CMD_TEST_IO  = 8'h00;
	localparam logic [7:0] CSD_CMD_NOP      = 8'h03;
	localparam logic [7:0] CSD_CMD_SENSE    = 8'h04;
	localparam logic [7:0] CSD_CMD_SELECT   = 8'h0B;
	localparam logic [7:0] CSD_CMD_ERASE    = 8'h0F;
	localparam logic [7:0] CSD_CMD_SENSE_IDENTIFICATION_CMD = 8'hE4;
	// =========================================================
	// status byte bits
	localparam logic [7:0] CSD_ST_ATTN = 8'h80;
	localparam logic [7:0] CSD_ST_SM   = 8'h40;
	localparam logic [7:0] CSD_ST_BUSY = 8'h10;
	localparam logic [7:0] CSD_ST_CE   = 8'h08;
	localparam logic [7:0] CSD_ST_DE   = 8'h04;
	localparam logic [7:0] CSD_ST_UC   = 8'h02;
	localparam logic [7:0] CSD_ST_PEND = 8'h96;
	// =========================================================
	// types
	typedef enum logic [1:0] {
		CSD_WK_ADR_DROP, CSD_WK_CMD_UP, CSD_WK_SC_UP, CSD_WK_DROP
	} csd_wait_t;
	typedef enum logic [1:0] {
		CSD_TE_NONE, CSD_TE_GO, CSD_TE_SRES, CSD_TE_IDSC
	} csd_tev_t;
	typedef enum logic [2:0] {
		CSD_CC_REJ, CSD_CC_SID, CSD_CC_TIO, CSD_CC_NOP, CSD_CC_SNS,
		CSD_CC_FWD
	} csd_cmd_t;
	typedef enum logic [4:0] {
		CSD_S_IDLE = 5'h00, CSD_S_SEL = 5'h01, CSD_S_INIT = 5'h03,
		CSD_S_ECHO = 5'h02, CSD_S_CWAIT = 5'h06, CSD_S_CCHK = 5'h07,
		CSD_S_STRD = 5'h05, CSD_S_DEC = 5'h04, CSD_S_SEND = 5'h0C,
		CSD_S_SLD = 5'h0D, CSD_S_SWAIT = 5'h0F, CSD_S_SPRES = 5'h0E,
		CSD_S_SPWAIT = 5'h0A, CSD_S_REL = 5'h0B, CSD_S_FWD = 5'h09,
		CSD_S_DISC = 5'h08, CSD_S_SRES = 5'h18, CSD_S_CERR = 5'h19
	} csd_state_t;
endpackage : csd_pkg

// [sim/channel_selection_cmd_decode_tb_top.sv]
`timescale 1ns/1ns
module channel_selection_cmd_decode_tb_top;
	import csd_pkg::*;
	localparam logic [6:0]  DEV = 7'h03;
	localparam logic [7:0]  ADR = {3'h2, 5'h03};
	localparam logic [31:0] CTL = 32'h0000_0201;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, bus_out, inbound_bus_drive, lpb_cmd;
	logic [31:0] pwdata, prdata, rdv;
	logic        select_in_tag, address_out_tag, operational_out_tag;
	logic        command_out_tag, service_out_tag, bus_out_parity;
	logic        inbound_bus_parity, operational_in_tag, address_in_tag;
	logic        status_in_tag, service_in_tag, lpb_cmd_valid, lpb_selres;
	logic        erv;
	logic [4:0]  lpb_dev;
	logic [7:0]  ids[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic [7:0]  fw[2] = '{CSD_CMD_SELECT, CSD_CMD_ERASE};
	int          num_errors, n_tests, n_fwd, n_sres, cyc;

	csd_sel_decode i_csd_sel_decode (.*);
	csd_chan_model i_csd_chan_model (.*);

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (lpb_cmd_valid === 1'b1) n_fwd++;
		if (lpb_selres === 1'b1) n_sres++;
		if (cyc == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	// =========================================================
	// compare and bus tasks
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: byte %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk32(rdv & m, e);
	endtask : rd

	task automatic mem(input logic [6:0] a, input logic [7:0] d);
		wr(CSD_REG_MADDR, {25'h0, a});
		wr(CSD_REG_MDATA, {24'h0, d});
	endtask : mem

	// one selection of the test device with expected ending status
	task automatic sc(input logic [7:0] c, input logic bp, input int ab,
		input logic [7:0] st, input int n);
		i_csd_chan_model.run(ADR, c, bp, ab);
		chk8({7'h0, i_csd_chan_model.answered}, 8'h01);
		if (ab == 0) begin
			chk8(i_csd_chan_model.stat, st);
			chk8(8'(i_csd_chan_model.data.size()), 8'(n));
		end
	endtask : sc

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// =========================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{num_errors, n_tests, n_fwd, n_sres, cyc} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CSD_REG_CTRL, 32'hFFFF_FFFF, CSD_CTRL_RST);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk8({7'h0, erv}, 8'h01);
		chk32(rdv, 32'h0000_0000);
		mem(CSD_STAT_BASE | DEV, 8'h00);
		mem(CSD_SENSE_BASE | DEV, 8'h5A);
		for (int i = 0; i < 4; i++) mem(CSD_ID_BASE + 7'(i), ids[i]);
		wr(CSD_REG_CTRL, CTL);
		rd(CSD_REG_CTRL, 32'hFFFF_FFFF, CTL);
		done("registers");
		i_csd_chan_model.run(8'h63, CSD_CMD_TEST_IO, 1'b0, 0);
		chk8({7'h0, i_csd_chan_model.answered}, 8'h00);
		sc(CSD_CMD_TEST_IO, 1'b0, 0, 8'h00, 0);
		chk8(i_csd_chan_model.echo, ADR);
		chk8({7'h0, i_csd_chan_model.echo_p}, 8'h01);
		rd(CSD_REG_LAST, 32'h0000_FFFF, {16'h0, CSD_CMD_TEST_IO, ADR});
		sc(CSD_CMD_NOP, 1'b0, 0, 8'h0C, 0);
		sc(CSD_CMD_SENSE, 1'b0, 0, 8'h0C, 1);
		chk8(i_csd_chan_model.data[0], 8'h5A);
		sc(CSD_CMD_SENSE_IDENTIFICATION_CMD, 1'b0, 0, 8'h0C, 4);
		for (int i = 0; i < 4; i++) chk8(i_csd_chan_model.data[i], ids[i]);
		foreach (fw[i]) begin
			sc(fw[i], 1'b0, 0, 8'h08, 0);
			chk8(lpb_cmd, fw[i]);
			chk8({3'h0, lpb_dev}, {1'b0, DEV});
		end
		chk8(8'(n_fwd), 8'h02);
		done("decode");
		sc(8'h55, 1'b0, 0, 8'h0E, 0);
		rd(CSD_REG_STAT, 32'h0000_0010, 32'h0000_0010);
		sc(CSD_CMD_TEST_IO, 1'b1, 0, 8'h0E, 0);
		rd(CSD_REG_STAT, 32'h0000_0008, 32'h0000_0008);
		wr(CSD_REG_STAT, 32'h0000_001E);
		rd(CSD_REG_STAT, 32'h0000_001E, 32'h0000_0000);
		mem(CSD_STAT_BASE | DEV, CSD_ST_ATTN);
		sc(CSD_CMD_NOP, 1'b0, 0, CSD_ST_ATTN, 0);
		mem(CSD_STAT_BASE | DEV, 8'h00);
		done("errors");
		wr(CSD_REG_CTRL, CTL | 32'h0003_0002);
		sc(CSD_CMD_TEST_IO, 1'b0, 0, CSD_ST_BUSY, 0);
		wr(CSD_REG_CTRL, CTL | 32'h0005_0002);
		sc(CSD_CMD_TEST_IO, 1'b0, 0, CSD_ST_BUSY | CSD_ST_SM, 0);
		rd(CSD_REG_STAT, 32'h0000_0006, 32'h0000_0000);
		wr(CSD_REG_CTRL, CTL);
		sc(CSD_CMD_TEST_IO, 1'b0, 1, 8'h00, 0);
		chk8(8'(n_sres), 8'h01);
		rd(CSD_REG_STAT, 32'h0000_0002, 32'h0000_0002);
		sc(CSD_CMD_TEST_IO, 1'b0, 2, 8'h00, 0);
		chk8({4'h0, operational_in_tag, address_in_tag, status_in_tag,
			service_in_tag}, 8'h00);
		rd(CSD_REG_STAT, 32'h0000_0004, 32'h0000_0004);
		sc(CSD_CMD_TEST_IO, 1'b0, 0, 8'h00, 0);
		done("busy and aborts");
		chk8(8'(i_csd_chan_model.hangs), 8'h00);
		end_of_test();
	end
endmodule : channel_selection_cmd_decode_tb_top

// [sim/csd_chan_model.sv]
`timescale 1ns/1ns
module csd_chan_model (
	// clock
	input  wire logic       pclk,
	// inbound pins
	input  wire logic [7:0] inbound_bus_drive,
	input  wire logic       inbound_bus_parity,
	input  wire logic       operational_in_tag,
	input  wire logic       address_in_tag,
	input  wire logic       status_in_tag,
	input  wire logic       service_in_tag,
	// outbound pins
	output logic            select_in_tag,
	output logic            address_out_tag,
	output logic            operational_out_tag,
	output logic            command_out_tag,
	output logic            service_out_tag,
	output logic      [7:0] bus_out,
	output logic            bus_out_parity
);
	logic [7:0] echo, stat, got;
	logic [7:0] data[$];
	logic       answered, echo_p;
	int         lim, hangs;

	initial begin
		{select_in_tag, address_out_tag, command_out_tag} = '0;
		service_out_tag = 1'b0;
		operational_out_tag = 1'b1;
		bus_out = 8'h00;
		bus_out_parity = 1'b1;
		hangs = 0;
	end

	function automatic logic tg(input int k);
		case (k)
			0: return operational_in_tag;
			1: return address_in_tag;
			2: return status_in_tag;
			default: return service_in_tag;
		endcase
	endfunction : tg

	// wait for an inbound tag to reach a level, bounded
	task automatic wt(input int k, input logic v);
		lim = 0;
		while (tg(k) !== v && lim < 80) begin
			@(posedge pclk);
			lim++;
		end
		if (lim == 80) hangs++;
	endtask : wt

	// take one inbound byte with a service out handshake
	task automatic take(input int k);
		got = inbound_bus_drive;
		service_out_tag <= 1'b1;
		wt(k, 1'b0);
		service_out_tag <= 1'b0;
		@(posedge pclk);
	endtask : take

	// =========================================================
	// one selection; abort 1 selective reset, 2 disconnect
	task automatic run(input logic [7:0] adr, input logic [7:0] cmd,
		input logic badp, input int abort);
		answered = 1'b0;
		data.delete();
		repeat (4) @(posedge pclk);
		bus_out <= adr;
		bus_out_parity <= ~^adr;
		select_in_tag <= 1'b1;
		address_out_tag <= 1'b1;
		lim = 0;
		while (operational_in_tag !== 1'b1 && status_in_tag !== 1'b1 &&
			lim < 20) begin
			@(posedge pclk);
			lim++;
		end
		answered = (lim < 20);
		if (status_in_tag === 1'b1) begin
			take(2);
			stat = got;
			select_in_tag <= 1'b0;
		end else if (answered) begin
			address_out_tag <= 1'b0;
			bus_out <= ~adr;
			wt(1, 1'b1);
			echo = inbound_bus_drive;
			echo_p = ^{inbound_bus_parity, inbound_bus_drive};
			if (abort == 1) operational_out_tag <= 1'b0;
			else if (abort == 2) address_out_tag <= 1'b1;
			else begin
				bus_out <= cmd;
				bus_out_parity <= ~^cmd ^ badp;
				command_out_tag <= 1'b1;
				wt(1, 1'b0);
				command_out_tag <= 1'b0;
				bus_out <= ~cmd;
				lim = 0;
				while (status_in_tag !== 1'b1 && lim < 80) begin
					if (service_in_tag === 1'b1) begin
						take(3);
						data.push_back(got);
					end else begin
						@(posedge pclk);
						lim++;
					end
				end
				take(2);
				stat = got;
				select_in_tag <= 1'b0;
			end
		end
		wt(0, 1'b0);
		@(posedge pclk);
		select_in_tag <= 1'b0;
		address_out_tag <= 1'b0;
		operational_out_tag <= 1'b1;
	endtask : run
endmodule : csd_chan_model

// [verilog/csd_comm_mem.sv]
`timescale 1ns/1ns
module csd_comm_mem (
	// clock
	input  wire logic                           pclk,
	// write port
	input  wire logic                           we,
	input  wire logic [csd_pkg::CSD_MEM_AW-1:0] waddr,
	input  wire logic [7:0]                     wdata,
	// read port
	input  wire logic [csd_pkg::CSD_MEM_AW-1:0] raddr,
	output logic      [7:0]                     rdata
);
	import csd_pkg::*;
	logic [7:0] mem [CSD_MEM_DEPTH];
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : csd_comm_mem

// [verilog/csd_sel_decode.sv]
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
// Operation
// - start only on Select in with valid address
// - fresh selection tests busy, clear goes initial
// - other device busy returns control-unit-busy status
// - same device busy returns plain Busy
// - capture address, raise Operational in, clear zero
// - zero cleared after wait means disconnect/reset
// - echo address on Bus in, raise Address in
// - wait for Command out rise before accepting
// - disconnect order drops at once, back idle
// - selective reset runs reset handling routine
// - command parity error enters command-error handling
// - sense command branches straight to sense
// - decode only when no pending device status
// - validity check then table-based command dispatch
// - select and erase forwarded to line processor
// - sense_identification_cmd sends four bytes 6F to 72
// - test I/O sends current status
// - no-op sends status-dependent information
// - sense sends addressed device sense byte
// - tag decode indexed by four outbound tags
// - abort in tag wait sets flag, clears zero
module csd_sel_decode (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// apb slave
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [7:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic            pready,
	output logic            pslverr,
	// channel outbound pins
	input  wire logic       select_in_tag,
	input  wire logic       address_out_tag,
	input  wire logic       operational_out_tag,
	input  wire logic       command_out_tag,
	input  wire logic       service_out_tag,
	input  wire logic [7:0] bus_out,
	input  wire logic       bus_out_parity,
	// channel inbound pins
	output logic      [7:0] inbound_bus_drive,
	output logic            inbound_bus_parity,
	output logic            operational_in_tag,
	output logic            address_in_tag,
	output logic            status_in_tag,
	output logic            service_in_tag,
	// line processor board
	output logic            lpb_cmd_valid,
	output logic      [7:0] lpb_cmd,
	output logic      [4:0] lpb_dev,
	output logic            lpb_selres
);
	import csd_pkg::*;
	// =========================================================
	// pin synchroniser
	logic [13:0] sy1_q, sy2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= {select_in_tag, address_out_tag,
				operational_out_tag, command_out_tag,
				service_out_tag, bus_out_parity, bus_out};
			sy2_q <= sy1_q;
		end
	end
	logic       sel_s, adr_s, cmd_s, srv_s;
	logic [3:0] tags;
	logic [7:0] bus_s;
	assign sel_s = sy2_q[13];
	assign adr_s = sy2_q[12];
	assign cmd_s = sy2_q[10];
	assign srv_s = sy2_q[9];
	assign tags  = sy2_q[12:9];
	assign bus_s = sy2_q[7:0];

	// =========================================================
	// decode functions
	function automatic csd_tev_t tag_decode(csd_wait_t k,
			logic [3:0] t);
		logic go;
		go = 1'b0;
		unique case (k)
			CSD_WK_ADR_DROP: go = !t[3];
			CSD_WK_CMD_UP:   go = t[1];
			CSD_WK_SC_UP:    go = t[1] | t[0];
			CSD_WK_DROP:     go = !(t[1] | t[0]);
		endcase
		if (!t[2])
			return CSD_TE_SRES;
		if (t[3] && k != CSD_WK_ADR_DROP)
			return CSD_TE_IDSC;
		return go ? CSD_TE_GO : CSD_TE_NONE;
	endfunction : tag_decode

	function automatic csd_cmd_t cmd_class(logic [7:0] c);
		unique case (c)
			CSD_CMD_SENSE_IDENTIFICATION_CMD: return CSD_CC_SID;
			CSD_CMD_TEST_IO:  return CSD_CC_TIO;
			CSD_CMD_NOP:      return CSD_CC_NOP;
			CSD_CMD_SENSE:    return CSD_CC_SNS;
			CSD_CMD_SELECT,
			CSD_CMD_ERASE:    return CSD_CC_FWD;
			default:          return CSD_CC_REJ;
		endcase
	endfunction : cmd_class

	// =========================================================
	// registers and memory
	logic [31:0] ctrl_q;
	logic [6:0]  maddr_q;
	logic        en, int_busy;
	logic [2:0]  cu_base;
	logic [4:0]  bdev;
	assign en       = ctrl_q[CSD_CTRL_EN];
	assign int_busy = ctrl_q[CSD_CTRL_BUSY];
	assign cu_base  = ctrl_q[CSD_CTRL_CU+:3];
	assign bdev     = ctrl_q[CSD_CTRL_BDEV+:5];

	csd_state_t st_q;
	logic [7:0] addr_q, cmd_q, sts_q;
	logic [6:0] ptr_q;
	logic [2:0] cnt_q;
	logic       zero_q, perr_q;
	logic       sres_f, idsc_f, cerr_f, crej_f;
	logic       ev_sres, ev_idsc, ev_cerr, ev_crej;
	logic [7:0] rdata;
	logic       wr_acc, mem_we;
	csd_wait_t  wk;
	csd_tev_t   tev;
	logic [4:0] dev;
	assign dev = addr_q[4:0];

	assign wr_acc = psel & penable & pwrite;
	assign mem_we = wr_acc && paddr == CSD_REG_MDATA;

	csd_comm_mem u_mem (
		.pclk  (pclk),
		.we    (mem_we),
		.waddr (maddr_q),
		.wdata (pwdata[7:0]),
		.raddr (ptr_q),
		.rdata (rdata)
	);

	// =========================================================
	// apb slave
	assign pready = 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= CSD_CTRL_RST;
			maddr_q <= '0;
		end else if (wr_acc) begin
			if (paddr == CSD_REG_CTRL)
				ctrl_q <= pwdata;
			if (paddr == CSD_REG_MADDR)
				maddr_q <= pwdata[6:0];
			if (mem_we)
				maddr_q <= maddr_q + 7'h01;
		end
	end

	logic [31:0] rd_mux;
	logic        unmapped;
	always_comb begin
		rd_mux   = '0;
		unmapped = 1'b0;
		unique case (paddr)
			CSD_REG_CTRL:  rd_mux = ctrl_q;
			CSD_REG_MADDR: rd_mux = {25'h0, maddr_q};
			CSD_REG_MDATA: rd_mux = '0;
			CSD_REG_STAT:  rd_mux = {19'h0, st_q, 3'h0, crej_f,
				cerr_f, idsc_f, sres_f, zero_q};
			CSD_REG_LAST:  rd_mux = {16'h0, cmd_q, addr_q};
			default:       unmapped = 1'b1;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= unmapped;
		end
	end

	// =========================================================
	// sticky program status flags, set wins over clear
	logic stat_wr;
	assign stat_wr = wr_acc && paddr == CSD_REG_STAT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sres_f <= 1'b0;
			idsc_f <= 1'b0;
			cerr_f <= 1'b0;
			crej_f <= 1'b0;
		end else begin
			sres_f <= ev_sres | (sres_f & ~(stat_wr &
				pwdata[CSD_STAT_SRES]));
			idsc_f <= ev_idsc | (idsc_f & ~(stat_wr &
				pwdata[CSD_STAT_IDSC]));
			cerr_f <= ev_cerr | (cerr_f & ~(stat_wr &
				pwdata[CSD_STAT_CERR]));
			crej_f <= ev_crej | (crej_f & ~(stat_wr &
				pwdata[CSD_STAT_CREJ]));
		end
	end

	// =========================================================
	// tag wait kind per state
	always_comb begin
		unique case (st_q)
			CSD_S_INIT:   wk = CSD_WK_ADR_DROP;
			CSD_S_CWAIT:  wk = CSD_WK_CMD_UP;
			CSD_S_SWAIT,
			CSD_S_SPWAIT: wk = CSD_WK_SC_UP;
			default:      wk = CSD_WK_DROP;
		endcase
	end
	// address out stays up from the selection until the channel sees
	// our answer; only a rise after it has dropped means disconnect
	logic       adr_low_q;
	logic [3:0] tags_m;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adr_low_q <= 1'b0;
		else if (st_q == CSD_S_IDLE)
			adr_low_q <= 1'b0;
		else if (!adr_s)
			adr_low_q <= 1'b1;
	end
	assign tags_m = {tags[3] & (adr_low_q | (wk == CSD_WK_ADR_DROP)),
		tags[2:0]};
	assign tev = tag_decode(wk, tags_m);

	logic waiting;
	assign waiting = st_q inside {CSD_S_INIT, CSD_S_CWAIT,
		CSD_S_SWAIT, CSD_S_SPWAIT, CSD_S_REL, CSD_S_SEND};
	assign inbound_bus_parity = ~^inbound_bus_drive;

	// =========================================================
	// selection and command sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q               <= CSD_S_IDLE;
			addr_q             <= '0;
			cmd_q              <= '0;
			sts_q              <= '0;
			ptr_q              <= '0;
			cnt_q              <= '0;
			zero_q             <= 1'b1;
			perr_q             <= 1'b0;
			inbound_bus_drive  <= '0;
			operational_in_tag <= 1'b0;
			address_in_tag     <= 1'b0;
			status_in_tag      <= 1'b0;
			service_in_tag     <= 1'b0;
			lpb_cmd_valid      <= 1'b0;
			lpb_cmd            <= '0;
			lpb_dev            <= '0;
			lpb_selres         <= 1'b0;
			ev_sres            <= 1'b0;
			ev_idsc            <= 1'b0;
			ev_cerr            <= 1'b0;
			ev_crej            <= 1'b0;
		end else begin
			lpb_cmd_valid <= 1'b0;
			lpb_selres    <= 1'b0;
			ev_sres       <= 1'b0;
			ev_idsc       <= 1'b0;
			ev_cerr       <= 1'b0;
			ev_crej       <= 1'b0;
			if (waiting && tev == CSD_TE_SRES) begin
				zero_q  <= 1'b0;
				ev_sres <= 1'b1;
				st_q    <= CSD_S_SRES;
			end else if (waiting && tev == CSD_TE_IDSC) begin
				zero_q  <= 1'b0;
				ev_idsc <= 1'b1;
				st_q    <= CSD_S_DISC;
			end else begin
				unique case (st_q)
				CSD_S_IDLE: begin
					if (en && sel_s && adr_s &&
							bus_s[7:5] == cu_base) begin
						addr_q <= bus_s;
						st_q   <= CSD_S_SEL;
					end
				end
				CSD_S_SEL: begin
					if (!int_busy) begin
						operational_in_tag <= 1'b1;
						zero_q <= 1'b0;
						st_q   <= CSD_S_INIT;
					end else begin
						sts_q <= (dev == bdev) ? CSD_ST_BUSY
							: (CSD_ST_SM | CSD_ST_BUSY);
						st_q  <= CSD_S_SPRES;
					end
				end
				CSD_S_INIT: begin
					if (tev == CSD_TE_GO) begin
						zero_q <= 1'b1;
						st_q   <= CSD_S_ECHO;
					end
				end
				CSD_S_ECHO: begin
					inbound_bus_drive <= addr_q;
					address_in_tag    <= 1'b1;
					st_q              <= CSD_S_CWAIT;
				end
				CSD_S_CWAIT: begin
					if (tev == CSD_TE_GO) begin
						cmd_q  <= bus_s;
						perr_q <= ~^sy2_q[8:0];
						st_q   <= CSD_S_CCHK;
					end
				end
				CSD_S_CCHK: begin
					address_in_tag <= 1'b0;
					if (perr_q) begin
						st_q <= CSD_S_CERR;
					end else if (cmd_class(cmd_q) == CSD_CC_SNS) begin
						ptr_q <= CSD_SENSE_BASE + {2'h0, dev};
						cnt_q <= 3'h1;
						st_q  <= CSD_S_SEND;
					end else begin
						ptr_q <= CSD_STAT_BASE + {2'h0, dev};
						st_q  <= CSD_S_STRD;
					end
				end
				CSD_S_STRD: st_q <= CSD_S_DEC;
				CSD_S_DEC: begin
					if ((rdata & CSD_ST_PEND) != 8'h00) begin
						sts_q <= rdata;
						st_q  <= CSD_S_SPRES;
					end else begin
						unique case (cmd_class(cmd_q))
						CSD_CC_SID: begin
							ptr_q <= CSD_ID_BASE;
							cnt_q <= CSD_ID_LEN;
							st_q  <= CSD_S_SEND;
						end
						CSD_CC_TIO: begin
							sts_q <= rdata;
							st_q  <= CSD_S_SPRES;
						end
						CSD_CC_NOP: begin
							sts_q <= rdata | CSD_ST_CE | CSD_ST_DE;
							st_q  <= CSD_S_SPRES;
						end
						CSD_CC_FWD: st_q <= CSD_S_FWD;
						default: begin
							sts_q   <= CSD_ST_CE | CSD_ST_DE | CSD_ST_UC;
							ev_crej <= 1'b1;
							st_q    <= CSD_S_SPRES;
						end
						endcase
					end
				end
				CSD_S_SEND: begin
					if (!srv_s && !cmd_s)
						st_q <= CSD_S_SLD;
				end
				CSD_S_SLD: begin
					inbound_bus_drive <= rdata;
					service_in_tag    <= 1'b1;
					ptr_q             <= ptr_q + 7'h01;
					cnt_q             <= cnt_q - 3'h1;
					st_q              <= CSD_S_SWAIT;
				end
				CSD_S_SWAIT: begin
					if (tev == CSD_TE_GO) begin
						service_in_tag <= 1'b0;
						sts_q <= CSD_ST_CE | CSD_ST_DE;
						st_q  <= (cnt_q == 3'h0 || cmd_s) ?
							CSD_S_SPRES : CSD_S_SEND;
					end
				end
				CSD_S_FWD: begin
					lpb_cmd_valid <= 1'b1;
					lpb_cmd       <= cmd_q;
					lpb_dev       <= dev;
					sts_q         <= CSD_ST_CE;
					st_q          <= CSD_S_SPRES;
				end
				CSD_S_CERR: begin
					ev_cerr <= 1'b1;
					sts_q   <= CSD_ST_CE | CSD_ST_DE | CSD_ST_UC;
					st_q    <= CSD_S_SPRES;
				end
				CSD_S_SPRES: begin
					// a stale service or command out must not take status
					if (!srv_s && !cmd_s) begin
						inbound_bus_drive <= sts_q;
						status_in_tag     <= 1'b1;
						st_q              <= CSD_S_SPWAIT;
					end
				end
				CSD_S_SPWAIT: begin
					if (tev == CSD_TE_GO) begin
						status_in_tag <= 1'b0;
						st_q          <= CSD_S_REL;
					end
				end
				CSD_S_REL: begin
					if (tev == CSD_TE_GO && !sel_s) begin
						operational_in_tag <= 1'b0;
						inbound_bus_drive  <= '0;
						zero_q             <= 1'b1;
						st_q               <= CSD_S_IDLE;
					end
				end
				CSD_S_DISC: begin
					operational_in_tag <= 1'b0;
					address_in_tag     <= 1'b0;
					status_in_tag      <= 1'b0;
					service_in_tag     <= 1'b0;
					inbound_bus_drive  <= '0;
					st_q               <= CSD_S_IDLE;
				end
				CSD_S_SRES: begin
					lpb_selres         <= 1'b1;
					lpb_dev            <= dev;
					operational_in_tag <= 1'b0;
					address_in_tag     <= 1'b0;
					status_in_tag      <= 1'b0;
					service_in_tag     <= 1'b0;
					inbound_bus_drive  <= '0;
					st_q               <= CSD_S_IDLE;
				end
				default: st_q <= CSD_S_IDLE;
				endcase
			end
		end
	end

	// =========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sel_start: assert property (
		st_q == CSD_S_IDLE && !(en && sel_s && adr_s)
		|=> st_q == CSD_S_IDLE)
		else $error("selection started without select");
	a_cu_busy: assert property (
		st_q == CSD_S_SEL && int_busy && dev != bdev
		|-> ##2 status_in_tag &&
		inbound_bus_drive == (CSD_ST_SM | CSD_ST_BUSY))
		else $error("control unit busy not returned");
	a_dev_busy: assert property (
		st_q == CSD_S_SEL && int_busy && dev == bdev
		|-> ##2 status_in_tag && inbound_bus_drive == CSD_ST_BUSY)
		else $error("device busy not returned");
	a_init_ack: assert property (
		st_q == CSD_S_SEL && !int_busy
		|=> operational_in_tag && !zero_q && st_q == CSD_S_INIT)
		else $error("initial selection not acknowledged");
	a_addr_echo: assert property (
		st_q == CSD_S_ECHO
		|=> address_in_tag && inbound_bus_drive == addr_q)
		else $error("address not echoed");
	a_cmd_hold: assert property (
		st_q == CSD_S_CWAIT && !cmd_s && operational_out_tag
		|=> st_q != CSD_S_CCHK)
		else $error("command taken before command out");
	a_perr_go: assert property (
		st_q == CSD_S_CCHK && perr_q
		|=> st_q == CSD_S_CERR ##2 cerr_f)
		else $error("parity error not handled");
	a_disc_idle: assert property (
		st_q == CSD_S_DISC
		|=> st_q == CSD_S_IDLE && !operational_in_tag)
		else $error("disconnect not immediate");
	a_sense_identification_cmd: assert property (
		st_q == CSD_S_DEC && cmd_class(cmd_q) == CSD_CC_SID &&
		(rdata & CSD_ST_PEND) == 8'h00
		|=> ptr_q == CSD_ID_BASE && cnt_q == CSD_ID_LEN)
		else $error("sense_identification_cmd setup wrong");
	a_fwd_pulse: assert property (
		st_q == CSD_S_FWD |=> lpb_cmd_valid && lpb_cmd == cmd_q)
		else $error("command not forwarded");
	a_abort_flag: assert property (
		waiting && tev == CSD_TE_SRES |=> !zero_q ##1 sres_f)
		else $error("selective reset flag not set");
endmodule : csd_sel_decode
